// >>> aci_pkg.sv
package aci_pkg;

  localparam logic [7:0] ACI_PAGE_CH1       = 8'h00;
  localparam logic [7:0] ACI_OFS_INPUT_CFG  = 8'h3C;
  localparam logic [7:0] ACI_OFS_GAIN_CFG   = 8'h3D;
  localparam logic [7:0] ACI_OFS_VOL_CFG    = 8'h3E;
  localparam logic [7:0] ACI_OFS_CAL_CFG    = 8'h3F;

  localparam logic [7:0] ACI_RST_INPUT_CFG  = 8'h00;
  localparam logic [7:0] ACI_RST_GAIN_CFG   = 8'h00;
  localparam logic [7:0] ACI_RST_VOL_CFG    = 8'hC9;
  localparam logic [7:0] ACI_RST_CAL_CFG    = 8'h80;

  // writable bits of each register; everything else is reserved
  localparam logic [7:0] ACI_MASK_INPUT_CFG = 8'hFD;
  localparam logic [7:0] ACI_MASK_GAIN_CFG  = 8'hFC;
  localparam logic [7:0] ACI_MASK_VOL_CFG   = 8'hFF;
  localparam logic [7:0] ACI_MASK_CAL_CFG   = 8'hF0;

  localparam int ACI_BIT_KIND     = 7;
  localparam int ACI_BIT_SRC_HI   = 6;
  localparam int ACI_BIT_SRC_LO   = 5;
  localparam int ACI_BIT_COUPLING = 4;
  localparam int ACI_BIT_IMP_HI   = 3;
  localparam int ACI_BIT_IMP_LO   = 2;
  localparam int ACI_BIT_RANGE_EN = 0;
  localparam int ACI_BIT_GAIN_HI  = 7;
  localparam int ACI_BIT_GAIN_LO  = 2;
  localparam int ACI_BIT_CAL_HI   = 7;
  localparam int ACI_BIT_CAL_LO   = 4;
  localparam int ACI_BIT_R108_SEL = 3;

  localparam logic [5:0] ACI_GAIN_MAX     = 6'h2A;
  localparam logic [7:0] ACI_VOL_MUTE     = 8'h00;
  localparam logic [8:0] ACI_VOL_ZERO_DB  = 9'h0C9;
  localparam logic [1:0] ACI_IMP_RESERVED = 2'h3;

  typedef enum logic [1:0] {
    ACI_SRC_DIFF = 2'b00,
    ACI_SRC_SE   = 2'b01,
    ACI_SRC_PDM  = 2'b10,
    ACI_SRC_RSVD = 2'b11
  } aci_source_t;

endpackage : aci_pkg

// >>> aci_ch_one_regs.sv
`timescale 1ns/1ps
module aci_ch_one_regs
  import aci_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // internal register port behind the serial control decoder
  input  wire logic [7:0]        reg_page,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr_en,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd_en,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rd_valid,
  output logic                   reg_hit,
  // bit 3 of page0_register_108, held elsewhere on this clock
  input  wire logic              page0_register_108_sel,
  output logic                   ch_one_input_kind,
  output aci_source_t            ch_one_input_source,
  output logic                   ch_one_source_analog,
  output logic                   ch_one_source_reserved,
  output logic                   ch_one_coupling_sel,
  output logic [1:0]             ch_one_impedance_sel,
  output logic                   ch_one_impedance_reserved,
  output logic                   ch_one_range_enh_en,
  output logic                   dynamic_range_enhancer_en,
  output logic                   automatic_gain_controller_en,
  output logic [5:0]             ch_one_gain_setting,
  output logic                   ch_one_gain_reserved,
  output logic [7:0]             ch_one_digital_volume,
  output logic                   ch_one_mute,
  output logic signed [8:0]      ch_one_volume_half_db,
  output logic [3:0]             ch_one_gain_cal
);

  ////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] input_cfg_ff;
  logic [7:0] gain_cfg_ff;
  logic [7:0] vol_cfg_ff;
  logic [7:0] cal_cfg_ff;
  logic [7:0] nxt_input_cfg;
  logic [7:0] nxt_gain_cfg;
  logic [7:0] nxt_vol_cfg;
  logic [7:0] nxt_cal_cfg;
  logic       page_ok;

  assign page_ok = (reg_page == ACI_PAGE_CH1);

  // only writable bits are taken; reserved bits stay at zero
  always_comb begin
    nxt_input_cfg = input_cfg_ff;
    nxt_gain_cfg  = gain_cfg_ff;
    nxt_vol_cfg   = vol_cfg_ff;
    nxt_cal_cfg   = cal_cfg_ff;
    if (reg_wr_en && page_ok) begin
      case (reg_addr)
        ACI_OFS_INPUT_CFG:
          nxt_input_cfg = reg_wdata & ACI_MASK_INPUT_CFG;
        ACI_OFS_GAIN_CFG:
          nxt_gain_cfg  = reg_wdata & ACI_MASK_GAIN_CFG;
        ACI_OFS_VOL_CFG:
          nxt_vol_cfg   = reg_wdata & ACI_MASK_VOL_CFG;
        ACI_OFS_CAL_CFG:
          nxt_cal_cfg   = reg_wdata & ACI_MASK_CAL_CFG;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      input_cfg_ff <= ACI_RST_INPUT_CFG;
      gain_cfg_ff  <= ACI_RST_GAIN_CFG;
      vol_cfg_ff   <= ACI_RST_VOL_CFG;
      cal_cfg_ff   <= ACI_RST_CAL_CFG;
    end else if (clk_en) begin
      input_cfg_ff <= nxt_input_cfg;
      gain_cfg_ff  <= nxt_gain_cfg;
      vol_cfg_ff   <= nxt_vol_cfg;
      cal_cfg_ff   <= nxt_cal_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: data one cycle after the strobe, unmapped reads give zero
  logic [7:0] rdata_ff;
  logic       rd_valid_ff;
  logic       hit_ff;
  logic [7:0] nxt_rdata;
  logic       nxt_rd_valid;
  logic       nxt_hit;

  always_comb begin
    nxt_rdata    = 8'h00;
    nxt_hit      = 1'b0;
    nxt_rd_valid = reg_rd_en;
    if (reg_rd_en && page_ok) begin
      nxt_hit = 1'b1;
      case (reg_addr)
        ACI_OFS_INPUT_CFG: nxt_rdata = input_cfg_ff;
        ACI_OFS_GAIN_CFG:  nxt_rdata = gain_cfg_ff;
        ACI_OFS_VOL_CFG:   nxt_rdata = vol_cfg_ff;
        ACI_OFS_CAL_CFG:   nxt_rdata = cal_cfg_ff;
        default:           nxt_hit   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff    <= 8'h00;
      rd_valid_ff <= 1'b0;
      hit_ff      <= 1'b0;
    end else if (clk_en) begin
      rdata_ff    <= nxt_rdata;
      rd_valid_ff <= nxt_rd_valid;
      hit_ff      <= nxt_hit;
    end
  end

  assign reg_rdata    = rdata_ff;
  assign reg_rd_valid = rd_valid_ff;
  assign reg_hit      = hit_ff;

  ////////////////////////////////////////////////////////////////////////
  // field decode; all straight from the register flops, engine enables also gated by page0_register_108_sel
  assign ch_one_input_kind   = input_cfg_ff[ACI_BIT_KIND];
  assign ch_one_input_source =
    aci_source_t'(input_cfg_ff[ACI_BIT_SRC_HI:ACI_BIT_SRC_LO]);
  assign ch_one_source_analog =
    (ch_one_input_source == ACI_SRC_DIFF) ||
    (ch_one_input_source == ACI_SRC_SE);
  assign ch_one_source_reserved = (ch_one_input_source == ACI_SRC_RSVD);
  // coupling has no meaning for a PDM microphone, so it is forced to AC
  assign ch_one_coupling_sel =
    input_cfg_ff[ACI_BIT_COUPLING] & ch_one_source_analog;
  assign ch_one_impedance_sel =
    input_cfg_ff[ACI_BIT_IMP_HI:ACI_BIT_IMP_LO];
  assign ch_one_impedance_reserved =
    (ch_one_impedance_sel == ACI_IMP_RESERVED);

  assign ch_one_range_enh_en = input_cfg_ff[ACI_BIT_RANGE_EN];
  // at most one of the two engines may run; the select is live
  assign dynamic_range_enhancer_en =
    ch_one_range_enh_en & ~page0_register_108_sel;
  assign automatic_gain_controller_en =
    ch_one_range_enh_en & page0_register_108_sel;

  assign ch_one_gain_setting =
    gain_cfg_ff[ACI_BIT_GAIN_HI:ACI_BIT_GAIN_LO];
  // reserved gain codes are stored as written; the flag lets the
  // analog side clamp rather than guess
  assign ch_one_gain_reserved = (ch_one_gain_setting > ACI_GAIN_MAX);

  assign ch_one_digital_volume = vol_cfg_ff;
  assign ch_one_mute = (vol_cfg_ff == ACI_VOL_MUTE);
  // signed half-dB steps relative to 0 dB: code 1 is -200, 255 is +54
  assign ch_one_volume_half_db =
    $signed({1'b0, vol_cfg_ff}) - $signed(ACI_VOL_ZERO_DB);

  assign ch_one_gain_cal = cal_cfg_ff[ACI_BIT_CAL_HI:ACI_BIT_CAL_LO];

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_input_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    input_cfg_ff[1] == 1'b0 && gain_cfg_ff[1:0] == 2'h0 &&
    cal_cfg_ff[3:0] == 4'h0)
    else $error("reserved bit holds a one");

  chk_input_write_lands: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && reg_wr_en && page_ok && reg_addr == ACI_OFS_INPUT_CFG
    |=> input_cfg_ff == ($past(reg_wdata) & ACI_MASK_INPUT_CFG))
    else $error("input cfg write not stored");

  chk_vol_write_lands: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && reg_wr_en && page_ok && reg_addr == ACI_OFS_VOL_CFG
    |=> ch_one_digital_volume == $past(reg_wdata))
    else $error("volume write not stored");

  chk_engine_exclusive: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ch_one_range_enh_en |->
    (dynamic_range_enhancer_en ^ automatic_gain_controller_en) &&
    (automatic_gain_controller_en == page0_register_108_sel))
    else $error("range engine select wrong");

  chk_engine_off: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !input_cfg_ff[ACI_BIT_RANGE_EN] |->
    !dynamic_range_enhancer_en && !automatic_gain_controller_en)
    else $error("range engine on while disabled");

  chk_mute_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && reg_wr_en && page_ok && reg_addr == ACI_OFS_VOL_CFG
    |=> ch_one_mute == ($past(reg_wdata) == 8'h00))
    else $error("mute does not follow code zero");

  chk_vol_map: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (ch_one_digital_volume == 8'h01 |-> ch_one_volume_half_db == -200) and
    (ch_one_digital_volume == 8'hFF |-> ch_one_volume_half_db == 54))
    else $error("volume map off");

  chk_coupling_pdm: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ch_one_input_source == ACI_SRC_PDM |-> !ch_one_coupling_sel)
    else $error("coupling active on digital source");

  chk_gain_flag: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ch_one_gain_reserved == (gain_cfg_ff[7:2] >= 6'h2B))
    else $error("gain reserved flag wrong");

  chk_read_answer: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en && reg_rd_en && page_ok && reg_addr == ACI_OFS_CAL_CFG
    |=> reg_rd_valid && reg_hit && reg_rdata == $past(cal_cfg_ff))
    else $error("calibration read wrong");

  chk_reset_values: assert property (
    @(posedge clk_sys) $fell(sys_rst) |->
    vol_cfg_ff == 8'hC9 && cal_cfg_ff == 8'h80 && input_cfg_ff == 8'h00)
    else $error("reset value wrong");

  cov_pdm_select: cover property (
    @(posedge clk_sys) disable iff (sys_rst)
    ch_one_input_source == ACI_SRC_PDM);
  cov_agc_on: cover property (
    @(posedge clk_sys) disable iff (sys_rst)
    automatic_gain_controller_en);
  cov_mute: cover property (
    @(posedge clk_sys) disable iff (sys_rst) ch_one_mute);
  cov_unmapped_read: cover property (
    @(posedge clk_sys) disable iff (sys_rst) reg_rd_valid && !reg_hit);

endmodule : aci_ch_one_regs

// >>> aci_ch_one_regs_tb.sv
`timescale 1ns/1ps
module tb;
  import aci_pkg::*;

  logic              clk_sys;
  logic              sys_rst;
  logic              clk_en;
  logic [7:0]        reg_page;
  logic [7:0]        reg_addr;
  logic              reg_wr_en;
  logic [7:0]        reg_wdata;
  logic              reg_rd_en;
  logic [7:0]        reg_rdata;
  logic              reg_rd_valid;
  logic              reg_hit;
  logic              sel;
  logic              kind;
  aci_source_t       src;
  logic              analog;
  logic              src_rsvd;
  logic              dc;
  logic [1:0]        imp;
  logic              imp_rsvd;
  logic              rng_en;
  logic              dre_en;
  logic              agc_en;
  logic [5:0]        gain;
  logic              gain_rsvd;
  logic [7:0]        vol;
  logic              mute;
  logic signed [8:0] half_db;
  logic [3:0]        gcal;
  int                err_count;
  int                checked;
  logic [7:0]        rst_v [4];

  aci_ch_one_regs uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit),
    .page0_register_108_sel(sel), .ch_one_input_kind(kind),
    .ch_one_input_source(src), .ch_one_source_analog(analog),
    .ch_one_source_reserved(src_rsvd), .ch_one_coupling_sel(dc),
    .ch_one_impedance_sel(imp), .ch_one_impedance_reserved(imp_rsvd),
    .ch_one_range_enh_en(rng_en), .dynamic_range_enhancer_en(dre_en),
    .automatic_gain_controller_en(agc_en), .ch_one_gain_setting(gain),
    .ch_one_gain_reserved(gain_rsvd), .ch_one_digital_volume(vol),
    .ch_one_mute(mute), .ch_one_volume_half_db(half_db),
    .ch_one_gain_cal(gcal));

  always #2 clk_sys = ~clk_sys;

  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [8:0] e,
                     input logic [8:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // ends just after the taking edge so decode outputs can be checked
  task automatic wr(input logic [7:0] p, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk_sys);
    reg_page  <= p;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] p, input logic [7:0] a,
                    input logic h, input logic [7:0] e);
    @(posedge clk_sys);
    reg_page  <= p;
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    chk("rd_valid", 9'(1'b1), 9'(reg_rd_valid));
    chk("hit", 9'(h), 9'(reg_hit));
    chk("rdata", 9'(e), 9'(reg_rdata));
  endtask : rd

  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic rst_check();
    for (int i = 0; i < 4; i++) begin
      rd(8'h00, 8'(ACI_OFS_INPUT_CFG + i), 1'b1, rst_v[i]);
    end
    chk("half_db", 9'h000, half_db);
  endtask : rst_check

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys   = 1'b0;
    sys_rst   = 1'b1;
    clk_en    = 1'b1;
    reg_page  = 8'h00;
    reg_addr  = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
    sel       = 1'b0;
    err_count = 0;
    checked   = 0;
    rst_v     = '{8'h00, 8'h00, 8'hC9, 8'h80};
    do_reset();
    rst_check();
    // unmapped offset and foreign page both miss
    rd(8'h00, 8'h40, 1'b0, 8'h00);
    wr(8'h01, ACI_OFS_VOL_CFG, 8'h11);
    rd(8'h01, ACI_OFS_VOL_CFG, 1'b0, 8'h00);
    rd(8'h00, ACI_OFS_VOL_CFG, 1'b1, 8'hC9);
    // all ones: reserved bits drop, reserved codes are flagged
    wr(8'h00, ACI_OFS_INPUT_CFG, 8'hFF);
    chk("kind", 9'h001, 9'(kind));
    chk("src_rsvd", 9'h001, 9'(src_rsvd));
    chk("dc", 9'h000, 9'(dc));
    chk("imp_rsvd", 9'h001, 9'(imp_rsvd));
    rd(8'h00, ACI_OFS_INPUT_CFG, 1'b1, 8'hFD);
    for (int s = 0; s < 3; s++) begin
      wr(8'h00, ACI_OFS_INPUT_CFG, {1'b0, 2'(s), 5'b11001});
      chk("kind", 9'h000, 9'(kind));
      chk("src", 9'(s), 9'(src));
      chk("analog", 9'(s < 2), 9'(analog));
      chk("dc", 9'(s < 2), 9'(dc));
      chk("imp", 9'h002, 9'(imp));
      chk("rng_en", 9'h001, 9'(rng_en));
      @(posedge clk_sys);
      sel <= (s != 0);
      #1;
      chk("dre", 9'(s == 0), 9'(dre_en));
      chk("agc", 9'(s != 0), 9'(agc_en));
    end
    wr(8'h00, ACI_OFS_INPUT_CFG, 8'h08);
    chk("imp", 9'h002, 9'(imp));
    chk("dre", 9'h000, 9'(dre_en));
    chk("rng_en", 9'h000, 9'(rng_en));
    chk("agc", 9'h000, 9'(agc_en));
    wr(8'h00, ACI_OFS_GAIN_CFG, 8'hA8);
    chk("gain", 9'h02A, 9'(gain));
    chk("gain_rsvd", 9'h000, 9'(gain_rsvd));
    wr(8'h00, ACI_OFS_GAIN_CFG, 8'hAF);
    chk("gain_rsvd", 9'h001, 9'(gain_rsvd));
    rd(8'h00, ACI_OFS_GAIN_CFG, 1'b1, 8'hAC);
    for (int c = 0; c < 256; c += 51) begin
      wr(8'h00, ACI_OFS_VOL_CFG, 8'(c));
      chk("mute", 9'(c == 0), 9'(mute));
      chk("vol", 9'(c), 9'(vol));
      if (c != 0) begin
        chk("half_db", 9'(c - 201), half_db);
      end
    end
    wr(8'h00, ACI_OFS_VOL_CFG, 8'h01);
    chk("half_db", 9'h138, half_db);
    wr(8'h00, ACI_OFS_CAL_CFG, 8'hFF);
    chk("gcal", 9'h00F, 9'(gcal));
    rd(8'h00, ACI_OFS_CAL_CFG, 1'b1, 8'hF0);
    // frozen clock enable must drop the write
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(8'h00, ACI_OFS_CAL_CFG, 8'h30);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(8'h00, ACI_OFS_CAL_CFG, 1'b1, 8'hF0);
    do_reset();
    rst_check();
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    tally_and_finish();
  end
endmodule : tb
